// [common/bmpa_pkg.sv]
package bmpa_pkg;

  // Register byte addresses
  localparam logic [31:0] BMPA_CORE0_ADDR  = 32'h4E80_0000;
  localparam logic [31:0] BMPA_CORE1_ADDR  = 32'h4E80_0004;
  localparam logic [31:0] BMPA_EBI_ADDR    = 32'h4E80_0008;
  localparam logic [31:0] BMPA_BUSPRI_ADDR = 32'h4E80_000C;
  localparam logic [31:0] BMPA_STATUS_ADDR = 32'h4E80_0010;

  // Reset values and writable bits
  localparam logic [31:0] BMPA_CORE_RST    = 32'h0000_0004;
  localparam logic [31:0] BMPA_EBI_RST     = 32'h0000_0004;
  localparam logic [31:0] BMPA_BUSPRI_RST  = 32'h0000_0000;
  localparam logic [31:0] BMPA_CORE_MASK   = 32'h0000_0005;
  localparam logic [31:0] BMPA_EBI_MASK    = 32'h0000_0707;
  localparam logic [31:0] BMPA_BUSPRI_MASK = 32'h00F1_F1F1;

  // Field positions
  localparam int unsigned BMPA_ROT_BIT     = 2;
  localparam int unsigned BMPA_FIX_BIT     = 0;
  localparam int unsigned BMPA_EBI_FIX_LO  = 0;
  localparam int unsigned BMPA_BANK1_BIT   = 8;
  localparam int unsigned BMPA_BANK2_BIT   = 9;
  localparam int unsigned BMPA_BANK3_BIT   = 10;
  localparam int unsigned BMPA_SYS_ROT_BIT = 0;
  localparam int unsigned BMPA_SYS_ST_LO   = 4;
  localparam int unsigned BMPA_IMG_ROT_BIT = 8;
  localparam int unsigned BMPA_IMG_ST_LO   = 12;
  localparam int unsigned BMPA_APB_ROT_BIT = 16;
  localparam int unsigned BMPA_APB_ST_LO   = 20;
  localparam int unsigned BMPA_ST_SYS_LO   = 0;
  localparam int unsigned BMPA_ST_IMG_LO   = 4;
  localparam int unsigned BMPA_ST_APB_LO   = 8;
  localparam int unsigned BMPA_ST_EBI_LO   = 12;
  localparam int unsigned BMPA_ST_CORE_LO  = 16;

  // Master counts
  localparam int unsigned BMPA_SYS_N = 16;
  localparam int unsigned BMPA_IMG_N = 9;
  localparam int unsigned BMPA_APB_N = 9;
  localparam int unsigned BMPA_EBI_N = 4;

  // System bus request bit = reset priority position
  localparam int unsigned BMPA_SYS_CARD = 0, BMPA_SYS_MMC1 = 1, BMPA_SYS_DMA0 = 2;
  localparam int unsigned BMPA_SYS_USB_HOST = 10, BMPA_SYS_USB_DEV = 11, BMPA_SYS_MMC0 = 12;
  localparam int unsigned BMPA_SYS_CPU_DATA = 13, BMPA_SYS_CPU_INSN = 14, BMPA_SYS_DEFAULT = 15;

  // External bus requesters
  localparam int unsigned BMPA_EBI_STATIC = 0, BMPA_EBI_NAND = 1, BMPA_EBI_CARD = 2, BMPA_EBI_EXT = 3;

  // Fixed orders per code, position 0 in the low two bits
  localparam logic [3:0][7:0] BMPA_EBI_ORDER = {8'h93, 8'h9C, 8'hD8, 8'hE4};

  typedef struct packed {
    logic       rotate;
    logic [3:0] start;
  } bmpa_arb_cfg_t;

  typedef struct packed {
    logic rotate;
    logic img_first;
  } bmpa_core_cfg_t;

  typedef struct packed {
    logic       found;
    logic [3:0] idx;
  } bmpa_pick_t;

  // First requester found searching from start, wrapping at n
  function automatic bmpa_pick_t bmpa_pick(input logic [15:0] req, input int unsigned n, input logic [3:0] start);
    bmpa_pick_t  r;
    int unsigned j;
    r = '0;
    for (int unsigned k = 0; k < 16; k++) begin
      j = (32'(start) + k) % n;
      if (k < n && !r.found && req[j]) begin
        r.found = 1'b1;
        r.idx   = 4'(j);
      end
    end
    return r;
  endfunction

endpackage

// [design/bmpa_core_arb.sv]
`timescale 1ns/1ps
`default_nettype none
module bmpa_core_arb
  import bmpa_pkg::*;
(
  input  wire logic           pclk,
  input  wire logic           presetn,
  input  wire logic           clk_en,
  input  wire logic           sys_req,
  input  wire logic           img_req,
  input  wire logic           hold,
  input  wire bmpa_core_cfg_t cfg,
  output logic                grant_sys_r,
  output logic                grant_img_r
);
  logic last_img_r;
  logic last_img_nxt;
  logic grant_sys_nxt;
  logic grant_img_nxt;
  logic img_wins;

  always_comb begin
    img_wins      = cfg.rotate ? !last_img_r : cfg.img_first; // [RULE3]
    grant_sys_nxt = grant_sys_r;
    grant_img_nxt = grant_img_r;
    last_img_nxt  = last_img_r;
    if (!hold) begin // [RULE4]
      grant_img_nxt = img_req && (!sys_req || img_wins);
      grant_sys_nxt = sys_req && !grant_img_nxt;
      if (grant_img_nxt || grant_sys_nxt) begin
        last_img_nxt = grant_img_nxt; // [RULE12]
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      grant_sys_r <= 1'b0;
      grant_img_r <= 1'b0;
      last_img_r  <= 1'b1;
    end else if (clk_en) begin
      grant_sys_r <= grant_sys_nxt;
      grant_img_r <= grant_img_nxt;
      last_img_r  <= last_img_nxt;
    end
  end

  core_excl_a: assert property ( // [RULE4]
    @(posedge pclk) disable iff (!presetn) !(grant_sys_r && grant_img_r))
    else $error("both buses granted one port");
  core_fixed_a: assert property ( // [RULE3]
    @(posedge pclk) disable iff (!presetn) clk_en && !hold && !cfg.rotate && sys_req && img_req
      |=> grant_img_r == $past(cfg.img_first))
    else $error("fixed winner wrong");
  core_rotate_a: assert property ( // [RULE12]
    @(posedge pclk) disable iff (!presetn) clk_en && !hold && cfg.rotate && sys_req && img_req
      |=> grant_img_r != $past(last_img_r))
    else $error("rotation did not alternate");
endmodule // bmpa_core_arb
`default_nettype wire

// [design/bmpa_prio_arb.sv]
`timescale 1ns/1ps
`default_nettype none
module bmpa_prio_arb
  import bmpa_pkg::*;
#(
  parameter int unsigned N = BMPA_SYS_N
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          clk_en,
  input  wire logic [N-1:0]  req,
  input  wire logic          hold,
  input  wire bmpa_arb_cfg_t cfg,
  output logic      [N-1:0]  grant_r,
  output logic      [3:0]    grant_idx_r
);
  localparam logic [3:0] LAST_ROT = 4'(N - 2);
  localparam logic [3:0] DEF_IDX  = 4'(N - 1);

  logic [3:0]   last_r;
  logic [3:0]   last_nxt;
  logic [3:0]   idx_nxt;
  logic [3:0]   start;
  logic [N-1:0] grant_nxt;
  bmpa_pick_t   pick;

  always_comb begin
    if (cfg.rotate) begin
      start = (last_r == LAST_ROT) ? 4'h0 : 4'(last_r + 4'h1); // [RULE12]
    end else begin
      start = (cfg.start < DEF_IDX) ? cfg.start : 4'h0; // [RULE10]
    end
    pick      = bmpa_pick(16'(req[N-2:0]), N - 1, start); // [RULE11]
    grant_nxt = grant_r;
    idx_nxt   = grant_idx_r;
    last_nxt  = last_r;
    if (!hold) begin // [RULE13]
      idx_nxt            = pick.found ? pick.idx : DEF_IDX;
      grant_nxt          = '0;
      grant_nxt[idx_nxt] = 1'b1;
      if (pick.found) begin
        last_nxt = pick.idx;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      grant_r     <= N'(1) << (N - 1);
      grant_idx_r <= DEF_IDX;
      last_r      <= LAST_ROT;
    end else if (clk_en) begin
      grant_r     <= grant_nxt;
      grant_idx_r <= idx_nxt;
      last_r      <= last_nxt;
    end
  end

  grant_onehot_a: assert property (@(posedge pclk) disable iff (!presetn) $onehot(grant_r)) // [RULE8]
    else $error("grant not one-hot");
  grant_hold_a: assert property ( // [RULE13]
    @(posedge pclk) disable iff (!presetn) hold |=> $stable(grant_r))
    else $error("grant moved during a transfer");
  default_idle_a: assert property ( // [RULE13]
    @(posedge pclk) disable iff (!presetn) clk_en && !hold && req[N-2:0] == '0 |=> grant_r[N-1])
    else $error("default master not parked");
  reset_order_a: assert property ( // [RULE9]
    @(posedge pclk) disable iff (!presetn) clk_en && !hold && cfg.rotate && last_r == LAST_ROT && req[0]
      |=> grant_r[0])
    else $error("position 0 not first after reset point");
endmodule // bmpa_prio_arb
`default_nettype wire

// [design/bmpa_top.sv]
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// How it works
// RULE1: Core 0 register, bit 2 rotate, reset 4
// RULE2: Core 1 register, same layout, independent
// RULE3: Fixed mode bit 0 picks system or image
// RULE4: Two cores, one per memory port
// RULE5: External bus register bit 2 rotate, reset 4
// RULE6: Bits 1:0 pick one of four orders
// RULE7: Bits 10:8 choose bank memory types
// RULE8: Serve 16 system, 9 image, 9 peripheral masters
// RULE9: Reset order positions 0 through 15
// RULE10: Fixed order follows software register values
// RULE11: Rotation excludes default master, kept lowest
// RULE12: Granted master drops to lowest rotating place
// RULE13: Regrant only at boundaries, idle to default
module bmpa_top
  import bmpa_pkg::*;
(
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  clk_en,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [31:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic [BMPA_SYS_N-1:0] sys_req,
  input  wire logic                  sys_hold,
  output logic      [BMPA_SYS_N-1:0] sys_grant,
  input  wire logic [BMPA_IMG_N-1:0] img_req,
  input  wire logic                  img_hold,
  output logic      [BMPA_IMG_N-1:0] img_grant,
  input  wire logic [BMPA_APB_N-1:0] apb_req,
  input  wire logic                  apb_hold,
  output logic      [BMPA_APB_N-1:0] apb_grant,
  input  wire logic                  core0_sys_req,
  input  wire logic                  core0_img_req,
  input  wire logic                  core0_hold,
  output logic                       core0_grant_sys,
  output logic                       core0_grant_img,
  input  wire logic                  core1_sys_req,
  input  wire logic                  core1_img_req,
  input  wire logic                  core1_hold,
  output logic                       core1_grant_sys,
  output logic                       core1_grant_img,
  input  wire logic [BMPA_EBI_N-1:0] ebi_req,
  input  wire logic                  ebi_hold,
  output logic      [BMPA_EBI_N-1:0] ebi_grant,
  output logic                       first_bank_type,
  output logic                       second_bank_type,
  output logic                       third_bank_type
);

  logic [31:0]           core0_r;
  logic [31:0]           core0_nxt;
  logic [31:0]           core1_r;
  logic [31:0]           core1_nxt;
  logic [31:0]           ebi_r;
  logic [31:0]           ebi_nxt;
  logic [31:0]           buspri_r;
  logic [31:0]           buspri_nxt;
  logic [31:0]           prdata_r;
  logic [31:0]           prdata_nxt;
  logic                  pready_r;
  logic                  pready_nxt;
  logic                  pslverr_r;
  logic                  pslverr_nxt;
  logic                  hit_core0;
  logic                  hit_core1;
  logic                  hit_ebi;
  logic                  hit_buspri;
  logic                  hit_status;
  logic                  mapped;
  logic                  wr;
  logic [31:0]           status;
  logic [3:0]            sys_idx;
  logic [3:0]            img_idx;
  logic [3:0]            apb_idx;
  logic [BMPA_EBI_N-1:0] ebi_grant_r;
  logic [BMPA_EBI_N-1:0] ebi_grant_nxt;
  logic [1:0]            ebi_last_r;
  logic [1:0]            ebi_last_nxt;
  logic [1:0]            ebi_code;
  logic [1:0]            ord_idx;
  logic                  ebi_rot;
  bmpa_pick_t            ebi_pick;
  bmpa_arb_cfg_t         sys_cfg;
  bmpa_arb_cfg_t         img_cfg;
  bmpa_arb_cfg_t         apb_cfg;
  bmpa_core_cfg_t        core0_cfg;
  bmpa_core_cfg_t        core1_cfg;

  // APB slave: one wait state, answer on the second access cycle
  always_comb begin
    hit_core0   = (paddr == BMPA_CORE0_ADDR);
    hit_core1   = (paddr == BMPA_CORE1_ADDR);
    hit_ebi     = (paddr == BMPA_EBI_ADDR);
    hit_buspri  = (paddr == BMPA_BUSPRI_ADDR);
    hit_status  = (paddr == BMPA_STATUS_ADDR);
    mapped      = hit_core0 | hit_core1 | hit_ebi | hit_buspri | hit_status;
    wr          = psel && penable && pready_r && pwrite && mapped;
    status      = '0;
    status[BMPA_ST_SYS_LO +: 4]  = sys_idx;
    status[BMPA_ST_IMG_LO +: 4]  = img_idx;
    status[BMPA_ST_APB_LO +: 4]  = apb_idx;
    status[BMPA_ST_EBI_LO +: 4]  = ebi_grant_r;
    status[BMPA_ST_CORE_LO +: 4] = {core1_grant_img, core1_grant_sys, core0_grant_img, core0_grant_sys};
    pready_nxt  = psel && penable && !pready_r;
    prdata_nxt  = '0;
    pslverr_nxt = 1'b0;
    if (pready_nxt) begin
      pslverr_nxt = !mapped;
      if (!pwrite) begin
        prdata_nxt = ({32{hit_core0}} & core0_r) | ({32{hit_core1}} & core1_r) | ({32{hit_ebi}} & ebi_r)
                   | ({32{hit_buspri}} & buspri_r) | ({32{hit_status}} & status);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r  <= '0;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else if (clk_en) begin
      prdata_r  <= prdata_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;

  // Control registers
  always_comb begin
    core0_nxt  = core0_r;
    core1_nxt  = core1_r;
    ebi_nxt    = ebi_r;
    buspri_nxt = buspri_r;
    if (wr && hit_core0) begin
      core0_nxt = pwdata & BMPA_CORE_MASK; // [RULE1]
    end
    if (wr && hit_core1) begin
      core1_nxt = pwdata & BMPA_CORE_MASK; // [RULE2]
    end
    if (wr && hit_ebi) begin
      ebi_nxt = pwdata & BMPA_EBI_MASK; // [RULE5]
    end
    if (wr && hit_buspri) begin
      buspri_nxt = pwdata & BMPA_BUSPRI_MASK; // [RULE10]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core0_r  <= BMPA_CORE_RST;
      core1_r  <= BMPA_CORE_RST;
      ebi_r    <= BMPA_EBI_RST;
      buspri_r <= BMPA_BUSPRI_RST;
    end else if (clk_en) begin
      core0_r  <= core0_nxt;
      core1_r  <= core1_nxt;
      ebi_r    <= ebi_nxt;
      buspri_r <= buspri_nxt;
    end
  end

  assign first_bank_type  = ebi_r[BMPA_BANK1_BIT]; // [RULE7]
  assign second_bank_type = ebi_r[BMPA_BANK2_BIT]; // [RULE7]
  assign third_bank_type  = ebi_r[BMPA_BANK3_BIT]; // [RULE7]

  // Arbiter configuration from the registers
  always_comb begin
    core0_cfg = '{rotate: core0_r[BMPA_ROT_BIT], img_first: core0_r[BMPA_FIX_BIT]}; // [RULE1] [RULE3]
    core1_cfg = '{rotate: core1_r[BMPA_ROT_BIT], img_first: core1_r[BMPA_FIX_BIT]}; // [RULE2] [RULE3]
    sys_cfg   = '{rotate: !buspri_r[BMPA_SYS_ROT_BIT], start: buspri_r[BMPA_SYS_ST_LO +: 4]};
    img_cfg   = '{rotate: !buspri_r[BMPA_IMG_ROT_BIT], start: buspri_r[BMPA_IMG_ST_LO +: 4]};
    apb_cfg   = '{rotate: !buspri_r[BMPA_APB_ROT_BIT], start: buspri_r[BMPA_APB_ST_LO +: 4]};
  end

  bmpa_core_arb u_core0 ( // [RULE4]
    .pclk        (pclk),
    .presetn     (presetn),
    .clk_en      (clk_en),
    .sys_req     (core0_sys_req),
    .img_req     (core0_img_req),
    .hold        (core0_hold),
    .cfg         (core0_cfg),
    .grant_sys_r (core0_grant_sys),
    .grant_img_r (core0_grant_img)
  );

  bmpa_core_arb u_core1 ( // [RULE4]
    .pclk        (pclk),
    .presetn     (presetn),
    .clk_en      (clk_en),
    .sys_req     (core1_sys_req),
    .img_req     (core1_img_req),
    .hold        (core1_hold),
    .cfg         (core1_cfg),
    .grant_sys_r (core1_grant_sys),
    .grant_img_r (core1_grant_img)
  );

  bmpa_prio_arb #(.N(BMPA_SYS_N)) u_sys ( // [RULE8] [RULE9]
    .pclk        (pclk),
    .presetn     (presetn),
    .clk_en      (clk_en),
    .req         (sys_req),
    .hold        (sys_hold),
    .cfg         (sys_cfg),
    .grant_r     (sys_grant),
    .grant_idx_r (sys_idx)
  );

  bmpa_prio_arb #(.N(BMPA_IMG_N)) u_img ( // [RULE8]
    .pclk        (pclk),
    .presetn     (presetn),
    .clk_en      (clk_en),
    .req         (img_req),
    .hold        (img_hold),
    .cfg         (img_cfg),
    .grant_r     (img_grant),
    .grant_idx_r (img_idx)
  );

  bmpa_prio_arb #(.N(BMPA_APB_N)) u_apb ( // [RULE8]
    .pclk        (pclk),
    .presetn     (presetn),
    .clk_en      (clk_en),
    .req         (apb_req),
    .hold        (apb_hold),
    .cfg         (apb_cfg),
    .grant_r     (apb_grant),
    .grant_idx_r (apb_idx)
  );

  // External bus arbiter: four requesters, no default owner
  always_comb begin
    ebi_rot  = ebi_r[BMPA_ROT_BIT];
    ebi_code = ebi_r[BMPA_EBI_FIX_LO +: 2];
    ebi_pick = '0;
    ord_idx  = 2'h0;
    if (ebi_rot) begin
      ebi_pick = bmpa_pick(16'(ebi_req), BMPA_EBI_N, 4'(2'(ebi_last_r + 2'h1))); // [RULE5] [RULE12]
    end else begin
      for (int unsigned p = 0; p < BMPA_EBI_N; p++) begin
        ord_idx = BMPA_EBI_ORDER[ebi_code][2*p +: 2]; // [RULE6]
        if (!ebi_pick.found && ebi_req[ord_idx]) begin
          ebi_pick.found = 1'b1;
          ebi_pick.idx   = 4'(ord_idx);
        end
      end
    end
    ebi_grant_nxt = ebi_grant_r;
    ebi_last_nxt  = ebi_last_r;
    if (!ebi_hold) begin // [RULE13]
      ebi_grant_nxt = '0;
      if (ebi_pick.found) begin
        ebi_grant_nxt[ebi_pick.idx[1:0]] = 1'b1;
        ebi_last_nxt                     = ebi_pick.idx[1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ebi_grant_r <= '0;
      ebi_last_r  <= 2'h3;
    end else if (clk_en) begin
      ebi_grant_r <= ebi_grant_nxt;
      ebi_last_r  <= ebi_last_nxt;
    end
  end

  assign ebi_grant = ebi_grant_r;

  apb_ready_a: assert property (
    @(posedge pclk) disable iff (!presetn) clk_en && psel && penable && !pready_r |=> pready_r)
    else $error("access phase not answered in one wait state");
  core0_wr_a: assert property ( // [RULE1]
    @(posedge pclk) disable iff (!presetn) clk_en && wr && hit_core0
      |=> core0_r == ($past(pwdata) & BMPA_CORE_MASK))
    else $error("core 0 register write lost");
  core1_indep_a: assert property ( // [RULE2]
    @(posedge pclk) disable iff (!presetn) clk_en && wr && hit_core0 |=> $stable(core1_r))
    else $error("core 1 register disturbed");
  ebi_wr_a: assert property ( // [RULE5]
    @(posedge pclk) disable iff (!presetn) clk_en && wr && hit_ebi
      |=> ebi_r == ($past(pwdata) & BMPA_EBI_MASK))
    else $error("external bus register write lost");
  bank_type_a: assert property ( // [RULE7]
    @(posedge pclk) disable iff (!presetn)
      {third_bank_type, second_bank_type, first_bank_type} == ebi_r[BMPA_BANK3_BIT:BMPA_BANK1_BIT])
    else $error("bank type outputs wrong");
  ebi_ext_top_a: assert property ( // [RULE6]
    @(posedge pclk) disable iff (!presetn) clk_en && !ebi_hold && !ebi_rot && ebi_code == 2'h3
      && ebi_req[BMPA_EBI_EXT] |=> ebi_grant_r[BMPA_EBI_EXT])
    else $error("external requester not first in code 3");
  ebi_static_a: assert property ( // [RULE6]
    @(posedge pclk) disable iff (!presetn) clk_en && !ebi_hold && !ebi_rot && ebi_code != 2'h3
      && ebi_req[BMPA_EBI_STATIC] |=> ebi_grant_r[BMPA_EBI_STATIC])
    else $error("static controller not first");
  ebi_hold_a: assert property ( // [RULE13]
    @(posedge pclk) disable iff (!presetn) ebi_hold |=> $stable(ebi_grant_r))
    else $error("external grant moved during a transfer");
  ebi_onehot_a: assert property (
    @(posedge pclk) disable iff (!presetn) $onehot0(ebi_grant_r))
    else $error("external grant not one-hot");
endmodule // bmpa_top
`default_nettype wire

// [dv/bmpa_master_model.sv]
`timescale 1ns/1ps
`default_nettype none
module bmpa_master_model #(
  parameter int unsigned N   = 16,
  parameter int unsigned LEN = 3
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [N-1:0] req_add,
  input  wire logic [N-1:0] grant,
  output logic      [N-1:0] req,
  output logic              hold,
  output logic              start
);
  logic [7:0] cnt_r;

  // Transfer runs while the granted master still requests
  assign hold  = |(grant & req);
  assign start = hold && (cnt_r == 8'h00);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req   <= '0;
      cnt_r <= 8'h00;
    end else if (hold && cnt_r == 8'(LEN - 1)) begin
      req   <= (req & ~grant) | req_add;
      cnt_r <= 8'h00;
    end else begin
      req   <= req | req_add;
      cnt_r <= hold ? cnt_r + 8'h01 : 8'h00;
    end
  end
endmodule // bmpa_master_model
`default_nettype wire

// [dv/bmpa_top_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module bmpa_top_tb;
  import bmpa_pkg::*;
  logic        pclk = 1'b0, presetn = 1'b0, ce = 1'b1, creq = 1'b0, hz = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0;
  logic [15:0] req_add = 16'h0;
  logic [8:0]  breq = 9'h000;
  logic [3:0]  ebi_req = 4'h0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, err, sys_hold, sys_start, hold_q, c0s, c0i, c1s, c1i;
  logic [15:0] sys_req, sys_grant, grant_q;
  logic [8:0]  img_grant, apb_grant;
  logic [3:0]  ebi_grant, seen;
  logic [2:0]  banks;
  logic [1:0]  pair;
  int          failures = 0, check_count = 0;
  int          seq[$];
  int          ord[4][4] = '{'{0, 1, 2, 3}, '{0, 2, 1, 3}, '{0, 3, 1, 2}, '{3, 0, 1, 2}};

  bmpa_top dut_u (.pclk(pclk), .presetn(presetn), .clk_en(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sys_req(sys_req), .sys_hold(sys_hold), .sys_grant(sys_grant), .img_req(breq), .img_hold(hz),
    .img_grant(img_grant), .apb_req(breq), .apb_hold(hz), .apb_grant(apb_grant), .core0_sys_req(creq),
    .core0_img_req(creq), .core0_hold(hz), .core0_grant_sys(c0s), .core0_grant_img(c0i),
    .core1_sys_req(creq), .core1_img_req(creq), .core1_hold(hz), .core1_grant_sys(c1s),
    .core1_grant_img(c1i), .ebi_req(ebi_req), .ebi_hold(hz), .ebi_grant(ebi_grant),
    .first_bank_type(banks[0]), .second_bank_type(banks[1]), .third_bank_type(banks[2]));

  bmpa_master_model #(.N(16), .LEN(3)) master_u (.pclk(pclk), .presetn(presetn), .req_add(req_add),
    .grant(sys_grant), .req(sys_req), .hold(sys_hold), .start(sys_start));

  always #20 pclk = ~pclk;

  function automatic int idx_of(input logic [15:0] g);
    idx_of = -1;
    for (int i = 0; i < 16; i++) if (g[i] === 1'b1) idx_of = i;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) failures++;
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task automatic wait_seq(input int n);
    int k;
    k = 0;
    while (seq.size() < n && k < 400) begin
      @(posedge pclk);
      k++;
    end
    if (seq.size() < n) failures++;
  endtask

  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Log each new system bus transfer, grant must stay frozen while held
  always @(posedge pclk) begin
    if (sys_start) seq.push_back(idx_of(sys_grant));
    if (hold_q === 1'b1 && sys_grant !== grant_q) chk(32'(sys_grant), 32'(grant_q));
    hold_q  <= sys_hold;
    grant_q <= sys_grant;
  end

  initial begin
    #400000;
    failures++;
    finish_test();
  end

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(32'(sys_grant), 32'h0000_8000);
    rchk(BMPA_CORE0_ADDR, 32'h0000_0004);
    rchk(BMPA_CORE1_ADDR, 32'h0000_0004);
    rchk(BMPA_EBI_ADDR, 32'h0000_0004);
    rchk(BMPA_STATUS_ADDR, 32'h0000_088F);
    chk(32'(banks), 32'h0);
    xfer(1'b0, 32'h4E80_0014, 32'h0);
    chk(32'(err), 32'h1);
    chk(rd, 32'h0);
    // All rotating masters at once: served in reset order, default last
    req_add <= 16'h7FFF;
    @(posedge pclk);
    req_add <= 16'h0000;
    wait_seq(15);
    for (int i = 0; i < 15; i++) chk(32'(seq[i]), 32'(i));
    repeat (8) @(posedge pclk);
    chk(32'(sys_grant), 32'h0000_8000);
    // Fixed order starting at position 5
    seq.delete();
    xfer(1'b1, BMPA_BUSPRI_ADDR, 32'h0000_0051);
    req_add <= 16'h1084;
    @(posedge pclk);
    req_add <= 16'h0000;
    wait_seq(3);
    chk(32'(seq[0]), 32'd7);
    chk(32'(seq[1]), 32'd12);
    chk(32'(seq[2]), 32'd2);
    breq <= 9'h010;
    repeat (2) @(posedge pclk);
    chk(32'({img_grant, apb_grant}), 32'({9'h010, 9'h010}));
    breq <= 9'h000;
    xfer(1'b1, BMPA_CORE0_ADDR, 32'h0);
    creq <= 1'b1;
    repeat (2) @(posedge pclk);
    chk(32'({c0s, c0i}), 32'h2);
    xfer(1'b1, BMPA_CORE0_ADDR, 32'h1);
    @(posedge pclk);
    chk(32'({c0s, c0i}), 32'h1);
    rchk(BMPA_CORE0_ADDR, 32'h0000_0001);
    pair = {c1s, c1i};
    @(posedge pclk);
    chk(32'(pair ^ {c1s, c1i}), 32'h3);
    for (int c = 0; c < 4; c++) begin
      xfer(1'b1, BMPA_EBI_ADDR, 32'(c));
      seen = 4'hF;
      for (int p = 0; p < 4; p++) begin
        ebi_req <= seen;
        repeat (2) @(posedge pclk);
        chk(32'(ebi_grant), 32'(1 << ord[c][p]));
        seen[ord[c][p]] = 1'b0;
      end
      ebi_req <= 4'h0;
    end
    xfer(1'b1, BMPA_EBI_ADDR, 32'h0000_0704);
    ebi_req <= 4'hF;
    seen = 4'h0;
    @(posedge pclk);
    repeat (4) begin
      @(posedge pclk);
      seen = seen | ebi_grant;
    end
    chk(32'(seen), 32'hF);
    // Hold freezes rotating grants, then clock enable low freezes them too
    hz <= 1'b1;
    @(posedge pclk);
    seen = ebi_grant;
    pair = {c1s, c1i};
    repeat (2) @(posedge pclk);
    chk(32'(ebi_grant), 32'(seen));
    chk(32'({c1s, c1i}), 32'(pair));
    hz <= 1'b0;
    ce <= 1'b0;
    repeat (3) @(posedge pclk);
    chk(32'(ebi_grant), 32'(seen));
    chk(32'({c1s, c1i}), 32'(pair));
    ce <= 1'b1;
    ebi_req <= 4'h0;
    chk(32'(banks), 32'h7);
    rchk(BMPA_EBI_ADDR, 32'h0000_0704);
    finish_test();
  end
endmodule // bmpa_top_tb
`default_nettype wire
